// ==== logic/wsc_sequencer.sv ====
/*
 * Wake, shutdown and fast clock sequencer of the data-acquisition device.
 * Assumes a 25 MHz clk, pins arriving asynchronously, host commands on clk.
 */
// How it works
// - Hold reset 1.5 s after supply good
// - Wake pulse must last at least 1 us
// - Power control rises 1 us after wake
// - Loop enabled: clock and loop within 10 ms
// - Loop disabled: clock within 10 us
// - Loop disabled: no clock-ready signal
// - Clock ready 7.82 ms after clock start
// - Clock stops 1.95 ms after shutdown
// - Power control falls 2.93 ms after shutdown
// - Clock gated by reset, monitor, power, core supply
// - Turn-on timed from later supply/reset edge
// - Fast clock always starts low
// - Reset pulses on watchdog, waits for oscillator
`timescale 1ns/1ns
module wsc_sequencer #(
	parameter int LOOP_ON_CYCLES = wsc_pkg::LOOP_TURN_ON_CYC,
	parameter int SUPPLY_TICKS = wsc_pkg::SUPPLY_RESET_TICKS,
	parameter int HALF_DIV = wsc_pkg::FAST_HALF_DIV
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Asynchronous pins
	input wire logic osc_32k,
	input wire logic supply_above,
	input wire logic ext_reset_n,
	input wire logic core_supply_good,
	input wire logic wake,
	// Control from the host interface logic
	input wire logic locked_loop_enable,
	input wire logic shutdown_cmd,
	input wire logic watchdog_timeout,
	// Reset pin, open drain
	output logic reset_pin_o,
	output logic reset_pin_oe,
	// Host power and clock
	output logic host_power_control,
	output logic fast_host_clock,
	output logic frequency_locked_loop,
	output logic fast_clock_ready
);
	typedef enum {CK_OFF, CK_START, CK_RUN, CK_STOP} wsc_clk_state_t;

	wsc_pkg::wsc_pins_t pins_raw;
	wsc_pkg::wsc_pins_t pins_s;
	wsc_pkg::wsc_od_t rst_pin_q;
	wsc_clk_state_t ck_state_q;
	logic osc_q, tick, supply_ok, wdog_q, wdog_done, monitor_ok;
	logic wake_done, wake_seen_q, pwr_on_done, host_power_q;
	logic shut_q, dis_done, off_done, gate;
	logic plain_done, loop_done, turn_on_done, ready_done, ready_q;
	logic loop_q, fast_q;
	logic [7:0] div_q;

	// Pin synchronisation
	assign pins_raw = '{osc_32k: osc_32k, supply_above: supply_above,
		ext_reset_n: ext_reset_n, core_supply_good: core_supply_good, wake: wake};

	wsc_sync #(
		.WIDTH($bits(wsc_pkg::wsc_pins_t))
	) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.pin_in(pins_raw),
		.pin_sync(pins_s)
	);

	// Oscillator tick on rising edge
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			osc_q <= 1'b0;
		else
			osc_q <= pins_s.osc_32k;
	end

	assign tick = pins_s.osc_32k && !osc_q;

	// Supply monitor timeout, counts only once the oscillator runs
	wsc_delay #(
		.WIDTH(17),
		.TERM(17'(SUPPLY_TICKS))
	) u_supply (
		.clk(clk),
		.reset_n(reset_n),
		.run(pins_s.supply_above),
		.step(tick),
		.done(supply_ok)
	);

	// Watchdog reset pulse
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			wdog_q <= 1'b0;
		else if (watchdog_timeout)
			wdog_q <= 1'b1;
		else if (wdog_done)
			wdog_q <= 1'b0;
	end

	wsc_delay #(
		.WIDTH(4),
		.TERM(4'(wsc_pkg::WDOG_PULSE_TICKS))
	) u_wdog (
		.clk(clk),
		.reset_n(reset_n),
		.run(wdog_q),
		.step(tick),
		.done(wdog_done)
	);

	assign monitor_ok = supply_ok && !wdog_q;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rst_pin_q <= '{o: 1'b0, oe: 1'b1};
		else
			rst_pin_q <= '{o: 1'b0, oe: !monitor_ok};
	end

	assign reset_pin_o = rst_pin_q.o;
	assign reset_pin_oe = rst_pin_q.oe;

	// Wake pulse qualification
	wsc_delay #(
		.WIDTH(8),
		.TERM(8'(wsc_pkg::WAKE_MIN_CYC))
	) u_wake (
		.clk(clk),
		.reset_n(reset_n),
		.run(pins_s.wake),
		.step(1'b1),
		.done(wake_done)
	);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			wake_seen_q <= 1'b0;
		else if (wake_done && !host_power_q)
			wake_seen_q <= 1'b1;
		else if (pwr_on_done || host_power_q)
			wake_seen_q <= 1'b0;
	end

	// Power-on delay after wake
	wsc_delay #(
		.WIDTH(8),
		.TERM(8'(wsc_pkg::POWER_ON_CYC))
	) u_pwr_on (
		.clk(clk),
		.reset_n(reset_n),
		.run(wake_seen_q && !host_power_q),
		.step(1'b1),
		.done(pwr_on_done)
	);

	// Shutdown command latch
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			shut_q <= 1'b0;
		else if (shutdown_cmd && host_power_q && !off_done)
			shut_q <= 1'b1;
		else if (off_done)
			shut_q <= 1'b0;
	end

	wsc_delay #(
		.WIDTH(8),
		.TERM(8'(wsc_pkg::CLOCK_DISABLE_TICKS))
	) u_disable (
		.clk(clk),
		.reset_n(reset_n),
		.run(shut_q),
		.step(tick),
		.done(dis_done)
	);

	wsc_delay #(
		.WIDTH(8),
		.TERM(8'(wsc_pkg::POWER_OFF_TICKS))
	) u_power_off (
		.clk(clk),
		.reset_n(reset_n),
		.run(shut_q),
		.step(tick),
		.done(off_done)
	);

	// Host power control
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			host_power_q <= wsc_pkg::HOST_POWER_RST;
		else if (off_done)
			host_power_q <= 1'b0;
		else if (pwr_on_done)
			host_power_q <= 1'b1;
	end

	assign host_power_control = host_power_q;

	// Clock gate; timer restarts on the later rising edge
	assign gate = pins_s.ext_reset_n && monitor_ok && host_power_q
		&& pins_s.core_supply_good;

	wsc_delay #(
		.WIDTH(9),
		.TERM(9'(wsc_pkg::PLAIN_TURN_ON_CYC))
	) u_plain_on (
		.clk(clk),
		.reset_n(reset_n),
		.run(gate),
		.step(1'b1),
		.done(plain_done)
	);

	wsc_delay #(
		.WIDTH(18),
		.TERM(18'(LOOP_ON_CYCLES))
	) u_loop_on (
		.clk(clk),
		.reset_n(reset_n),
		.run(gate && locked_loop_enable),
		.step(1'b1),
		.done(loop_done)
	);

	assign turn_on_done = locked_loop_enable ? loop_done : plain_done;

	// Fast clock state
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ck_state_q <= CK_OFF;
		else
		begin
			case (ck_state_q)
				CK_OFF:
					if (gate && !shut_q)
						ck_state_q <= CK_START;
				CK_START:
					if (!gate || dis_done)
						ck_state_q <= CK_OFF;
					else if (turn_on_done)
						ck_state_q <= CK_RUN;
				CK_RUN:
					if (!gate || dis_done)
						ck_state_q <= CK_STOP;
				CK_STOP:
					if (!fast_q)
						ck_state_q <= CK_OFF;
				default:
					ck_state_q <= CK_OFF;
			endcase
		end
	end

	// Divider, starts low and stops only after a low phase begins
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			div_q <= '0;
			fast_q <= wsc_pkg::FAST_CLOCK_RST;
		end
		else if (ck_state_q == CK_RUN || (ck_state_q == CK_STOP && fast_q))
		begin
			if (div_q == 8'(HALF_DIV - 1))
			begin
				div_q <= '0;
				fast_q <= !fast_q;
			end
			else
				div_q <= div_q + 1'b1;
		end
		else
		begin
			div_q <= '0;
			fast_q <= 1'b0;
		end
	end

	assign fast_host_clock = fast_q;

	// Locked loop enable
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			loop_q <= 1'b0;
		else
			loop_q <= gate && locked_loop_enable && ck_state_q != CK_OFF
				&& ck_state_q != CK_STOP;
	end

	assign frequency_locked_loop = loop_q;

	// Clock-ready delay, only with the loop enabled
	wsc_delay #(
		.WIDTH(9),
		.TERM(9'(wsc_pkg::CLOCK_READY_TICKS))
	) u_ready (
		.clk(clk),
		.reset_n(reset_n),
		.run(ck_state_q == CK_RUN && locked_loop_enable),
		.step(tick),
		.done(ready_done)
	);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ready_q <= 1'b0;
		else
			ready_q <= ready_done && locked_loop_enable;
	end

	assign fast_clock_ready = ready_q;
endmodule : wsc_sequencer

// ==== logic/wsc_pkg.sv ====
/*
 * Shared constants and carrier types of the wake, shutdown and clock sequencer.
 * Assumes a 25 MHz system clock and a free-running 32 kHz oscillator input.
 */
package wsc_pkg;
	// System clock and oscillator
	localparam int CLK_HZ = 25000000;
	localparam real OSC_HZ = 32768.0;

	// Times in their own units
	localparam real SUPPLY_RESET_TIMEOUT_S = 1.5;
	localparam real WAKE_MIN_US = 1.0;
	localparam real POWER_ON_DELAY_US = 1.0;
	localparam real LOOP_TURN_ON_MS = 10.0;
	localparam real PLAIN_TURN_ON_US = 10.0;
	localparam real CLOCK_READY_DELAY_MS = 7.82;
	localparam real CLOCK_DISABLE_DELAY_MS = 1.95;
	localparam real POWER_OFF_DELAY_MS = 2.93;

	// System clock cycle counts
	localparam int WAKE_MIN_CYC = int'($ceil(WAKE_MIN_US * CLK_HZ / 1.0e6));
	localparam int POWER_ON_CYC = int'($ceil(POWER_ON_DELAY_US * CLK_HZ / 1.0e6));
	localparam int PLAIN_TURN_ON_CYC = int'($floor(PLAIN_TURN_ON_US * CLK_HZ / 1.0e6));
	localparam int LOOP_TURN_ON_CYC = int'($floor(LOOP_TURN_ON_MS * CLK_HZ / 1.0e3));

	// Oscillator tick counts, nearest to the typical delay
	localparam int SUPPLY_RESET_TICKS = int'(SUPPLY_RESET_TIMEOUT_S * OSC_HZ);
	localparam int CLOCK_READY_TICKS = int'(CLOCK_READY_DELAY_MS * OSC_HZ / 1.0e3);
	localparam int CLOCK_DISABLE_TICKS = int'(CLOCK_DISABLE_DELAY_MS * OSC_HZ / 1.0e3);
	localparam int POWER_OFF_TICKS = int'(POWER_OFF_DELAY_MS * OSC_HZ / 1.0e3);
	localparam int WDOG_PULSE_TICKS = 8;

	// Fast clock half period in system clocks
	localparam int FAST_HALF_DIV = 5;

	// Reset values
	localparam logic HOST_POWER_RST = 1'b0;
	localparam logic FAST_CLOCK_RST = 1'b0;

	// Pins from outside the clock domain
	typedef struct packed {
		logic osc_32k;
		logic supply_above;
		logic ext_reset_n;
		logic core_supply_good;
		logic wake;
	} wsc_pins_t;

	// Open-drain reset pin
	typedef struct packed {
		logic o;
		logic oe;
	} wsc_od_t;
endpackage : wsc_pkg

// ==== logic/wsc_sync.sv ====
/*
 * Two-flop synchroniser for a group of pins.
 * Assumes inputs are asynchronous to clk; only the second flop is read.
 */
`timescale 1ns/1ns
module wsc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Pins and synchronised copy
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_q <= '0;
			pin_sync <= '0;
		end
		else
		begin
			meta_q <= pin_in;
			pin_sync <= meta_q;
		end
	end
endmodule : wsc_sync

// ==== logic/wsc_delay.sv ====
/*
 * Delay counter: counts steps while run is high, clears when run drops.
 * Assumes step is a one-cycle strobe from the same clock domain.
 */
`timescale 1ns/1ns
module wsc_delay #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] TERM = '1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Control
	input wire logic run,
	input wire logic step,
	// Status
	output logic done
);
	logic [WIDTH-1:0] cnt_q;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			cnt_q <= '0;
		else if (!run)
			cnt_q <= '0;
		else if (step && cnt_q != TERM)
			cnt_q <= cnt_q + 1'b1;
	end

	assign done = run && (cnt_q == TERM);
endmodule : wsc_delay

// ==== sim/wsc_sequencer_checker.sv ====
/*
 * Port checker of the sequencer.
 * Assumes bind to wsc_sequencer with HALF_DIV of 5.
 */
`timescale 1ns/1ns
module wsc_sequencer_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Inputs
	input wire logic supply_above,
	input wire logic wake,
	input wire logic locked_loop_enable,
	input wire logic watchdog_timeout,
	// Outputs
	input wire logic reset_pin_o,
	input wire logic reset_pin_oe,
	input wire logic host_power_control,
	input wire logic fast_host_clock,
	input wire logic frequency_locked_loop,
	input wire logic fast_clock_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_od_low;
		reset_pin_o == 1'b0;
	endproperty
	a_od_low: assert property (p_od_low) else $error("reset pin driven high");
	property p_supply_hold;
		!supply_above [*4] |=> reset_pin_oe;
	endproperty
	a_supply_hold: assert property (p_supply_hold) else $error("reset released");
	property p_dog;
		$rose(watchdog_timeout) |-> ##[1:3] reset_pin_oe;
	endproperty
	a_dog: assert property (p_dog) else $error("no watchdog reset");
	property p_no_ready;
		!locked_loop_enable [*2] |=> !$rose(fast_clock_ready);
	endproperty
	a_no_ready: assert property (p_no_ready) else $error("ready without loop");
	property p_unpowered;
		!host_power_control |-> !fast_host_clock && !fast_clock_ready;
	endproperty
	a_unpowered: assert property (p_unpowered) else $error("clock while off");
	property p_high_phase;
		$rose(fast_host_clock) |-> fast_host_clock [*5] ##1 !fast_host_clock;
	endproperty
	a_high_phase: assert property (p_high_phase) else $error("clock glitch");
	property p_wake_first;
		$rose(host_power_control) |-> $past(wake, 30);
	endproperty
	a_wake_first: assert property (p_wake_first) else $error("power without wake");
	property p_power_off;
		$fell(host_power_control) |-> !fast_host_clock && !frequency_locked_loop;
	endproperty
	a_power_off: assert property (p_power_off) else $error("clock at power off");
	c_ready: cover property ($rose(fast_clock_ready));
	c_off: cover property ($fell(host_power_control));
	c_dog: cover property ($rose(watchdog_timeout));
endmodule : wsc_sequencer_checker

bind wsc_sequencer wsc_sequencer_checker wsc_sequencer_checker_inst (.clk, .reset_n,
	.supply_above, .wake, .locked_loop_enable, .watchdog_timeout, .reset_pin_o,
	.reset_pin_oe, .host_power_control, .fast_host_clock, .frequency_locked_loop,
	.fast_clock_ready);

// ==== sim/wsc_host_model.sv ====
/*
 * Host model: sends shutdown, tidies up on the fast clock.
 * Assumes go is a one-cycle strobe on clk.
 */
`timescale 1ns/1ns
module wsc_host_model (
	// Clock
	input wire logic clk,
	// Device side
	input wire logic host_power_control,
	input wire logic fast_host_clock,
	output logic shutdown_cmd = 1'b0,
	// Bench side
	input wire logic go,
	output int tidy_edges = 0,
	output int last_edge = 0
);
	int age = 0;
	logic clk_q = 1'b0;
	always @(posedge clk)
	begin
		clk_q <= fast_host_clock;
		shutdown_cmd <= go && host_power_control;
		age <= go ? 0 : age + 1;
		if (go)
			tidy_edges <= 0;
		else if (fast_host_clock && !clk_q)
		begin
			tidy_edges <= tidy_edges + 1;
			last_edge <= age;
		end
	end
endmodule : wsc_host_model

// ==== sim/wsc_sequencer_test.sv ====
/*
 * Testbench of the sequencer.
 * Assumes an 8-cycle oscillator to shorten tick delays.
 */
`timescale 1ns/1ns
module wsc_sequencer_test;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic osc_32k = 1'b0;
	logic supply_above = 1'b1;
	logic ext_reset_n = 1'b1;
	logic core_supply_good = 1'b1;
	logic wake = 1'b0;
	logic locked_loop_enable = 1'b0;
	logic watchdog_timeout = 1'b0;
	logic go = 1'b0;
	logic shutdown_cmd, reset_pin_o, reset_pin_oe, host_power_control;
	logic fast_host_clock, frequency_locked_loop, fast_clock_ready;
	int tidy_edges, last_edge, n;
	int cyc = 0;
	int fail_count = 0;
	int n_tests = 0;
	wsc_sequencer #(.LOOP_ON_CYCLES(50), .SUPPLY_TICKS(4), .HALF_DIV(5)) wsc_sequencer_inst (
		.clk, .reset_n, .osc_32k, .supply_above, .ext_reset_n, .core_supply_good, .wake,
		.locked_loop_enable, .shutdown_cmd, .watchdog_timeout, .reset_pin_o, .reset_pin_oe,
		.host_power_control, .fast_host_clock, .frequency_locked_loop, .fast_clock_ready);
	wsc_host_model wsc_host_model_inst (.clk, .host_power_control, .fast_host_clock,
		.shutdown_cmd, .go, .tidy_edges, .last_edge);
	initial forever #20 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc % 4 == 3)
			osc_32k <= ~osc_32k;
		if (cyc == 12000)
		begin
			fail_count++;
			end_of_test();
		end
	end
	task end_of_test;
		if (fail_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	task check(input string what, input logic [31:0] seen, input logic [31:0] lo,
		input logic [31:0] hi);
		n_tests++;
		if ((seen >= lo && seen <= hi) !== 1'b1)
		begin
			fail_count++;
			$display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, seen);
		end
	endtask : check
	function logic pick(input int i);
		case (i)
			0: pick = reset_pin_oe;
			1: pick = host_power_control;
			2: pick = fast_host_clock;
			3: pick = frequency_locked_loop;
			default: pick = fast_clock_ready;
		endcase
	endfunction : pick
	task wait_sig(input int i, input logic v, input int lim);
		n = 0;
		while (pick(i) !== v && n < lim)
		begin
			@(posedge clk);
			n++;
		end
	endtask : wait_sig
	task t_reset;
		repeat (8) @(posedge clk);
		check("reset pin", reset_pin_oe, 1, 1);
		check("clock", fast_host_clock, 0, 0);
		reset_n <= 1'b1;
		wait_sig(0, 1'b0, 100);
		check("supply timeout", n, 24, 48);
	endtask : t_reset
	task t_wake;
		wake <= 1'b1;
		repeat (10) @(posedge clk);
		wake <= 1'b0;
		wait_sig(1, 1'b1, 80);
		check("short wake", n, 80, 80);
		wake <= 1'b1;
		wait_sig(1, 1'b1, 100);
		wake <= 1'b0;
		check("power on", n, 48, 62);
	endtask : t_wake
	task t_plain;
		wait_sig(2, 1'b1, 400);
		check("plain start", n, 245, 265);
		wait_sig(4, 1'b1, 2200);
		check("no ready", n, 2200, 2200);
	endtask : t_plain
	task t_shut;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		wait_sig(1, 1'b0, 1000);
		check("power off", n, 756, 790);
		check("clock stop", last_edge, 490, 535);
		check("host tidy", tidy_edges > 40, 1, 1);
		check("clock off", fast_host_clock, 0, 0);
	endtask : t_shut
	task t_loop;
		locked_loop_enable <= 1'b1;
		wake <= 1'b1;
		wait_sig(1, 1'b1, 100);
		wake <= 1'b0;
		wait_sig(3, 1'b1, 4);
		check("loop on", n, 0, 3);
		wait_sig(2, 1'b1, 100);
		check("loop clock", n, 48, 64);
		wait_sig(4, 1'b1, 2200);
		check("ready delay", n, 2030, 2072);
	endtask : t_loop
	task t_wdog;
		watchdog_timeout <= 1'b1;
		@(posedge clk);
		watchdog_timeout <= 1'b0;
		wait_sig(0, 1'b1, 4);
		check("dog reset", n, 0, 3);
		wait_sig(0, 1'b0, 120);
		check("dog pulse", n, 56, 80);
	endtask : t_wdog
	task t_gate;
		ext_reset_n <= 1'b0;
		repeat (12) @(posedge clk);
		wait_sig(2, 1'b1, 100);
		check("gated", n, 100, 100);
		core_supply_good <= 1'b0;
		ext_reset_n <= 1'b1;
		repeat (40) @(posedge clk);
		core_supply_good <= 1'b1;
		wait_sig(2, 1'b1, 100);
		check("later edge", n, 52, 66);
	endtask : t_gate
	task t_supply;
		supply_above <= 1'b0;
		repeat (6) @(posedge clk);
		check("supply drop", reset_pin_oe, 1, 1);
		supply_above <= 1'b1;
		wait_sig(0, 1'b0, 100);
		check("supply return", n, 24, 48);
	endtask : t_supply
	initial
	begin
		t_reset();
		t_wake();
		t_plain();
		t_shut();
		t_loop();
		t_wdog();
		t_gate();
		t_supply();
		end_of_test();
	end
endmodule : wsc_sequencer_test
